// >>> hdl/hpal_capacity.sv
// Capacity figures reported in identify data for the current user limit.
`timescale 1ns/1ps
`default_nettype none
module hpal_capacity
	import hpal_pkg::*;
#(
	parameter int HEADS = 16,
	parameter int SPT   = 63
)
(
	input  wire logic              clk_sys_i,  // System clock
	input  wire logic              rst_n_i,    // Async reset, active low
	input  wire logic [ADDR_W-1:0] max_i,      // Current user maximum address
	output logic      [15:0]       cyl_o,      // Whole cylinders below limit
	output logic      [31:0]       chs_cap_o,  // Sectors in whole cylinders
	output logic      [31:0]       lba_cap_o   // Sectors up to and at limit
);

	localparam logic [31:0] CYL_SIZE = 32'(HEADS * SPT);

	logic [31:0] next_lba;
	logic [31:0] next_cyl;

	always_comb
	begin
		next_lba = {{(32 - ADDR_W){1'b0}}, max_i} + 32'h0000_0001;
		next_cyl = next_lba / CYL_SIZE;
	end

	// Capacity is registered so the divider stays off the read path.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cyl_o     <= 16'h0000;
			chs_cap_o <= 32'h0000_0000;
			lba_cap_o <= 32'h0000_0000;
		end
		else
		begin
			cyl_o     <= next_cyl[15:0];
			chs_cap_o <= next_cyl * CYL_SIZE;
			lba_cap_o <= next_lba;
		end
	end

endmodule
`default_nettype wire

// >>> hdl/hpal_pkg.sv
// Shared constants for the host protected area limit block.
package hpal_pkg;

	// Address width of the logical block space.
	localparam int ADDR_W = 28;

	// Register byte offsets on the plain register port.
	localparam logic [7:0] OFS_CMD        = 8'h00;
	localparam logic [7:0] OFS_ADDR       = 8'h04;
	localparam logic [7:0] OFS_SECCNT     = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0C;
	localparam logic [7:0] OFS_MASK       = 8'h10;
	localparam logic [7:0] OFS_RESULT     = 8'h14;
	localparam logic [7:0] OFS_USER_MAX   = 8'h18;
	localparam logic [7:0] OFS_NATIVE_MAX = 8'h1C;
	localparam logic [7:0] OFS_ID_INDEX   = 8'h20;
	localparam logic [7:0] OFS_ID_DATA    = 8'h24;
	localparam logic [7:0] OFS_FLAGS      = 8'h28;

	// Command codes written to the command register.
	localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
	localparam logic [7:0] CMD_SET_MAX     = 8'hF9;
	localparam logic [7:0] CMD_READ        = 8'h20;
	localparam logic [7:0] CMD_WRITE       = 8'h30;

	// Sector count register fields.
	localparam int SC_KEEP_BIT = 0;
	localparam int SC_CHS_BIT  = 1;

	// Status and mask register fields.
	localparam int ST_DONE_BIT  = 0;
	localparam int ST_ABORT_BIT = 1;
	localparam int ST_W         = 2;

	// Flags register fields.
	localparam int FL_NV_USED_BIT = 0;
	localparam int FL_ARMED_BIT   = 1;
	localparam int FL_BUSY_BIT    = 2;

	// Identify data word indices and the support bit.
	localparam logic [7:0] IDW_CYL       = 8'd1;
	localparam logic [7:0] IDW_HEADS     = 8'd3;
	localparam logic [7:0] IDW_SPT       = 8'd6;
	localparam logic [7:0] IDW_CUR_CYL   = 8'd54;
	localparam logic [7:0] IDW_CUR_HEADS = 8'd55;
	localparam logic [7:0] IDW_CUR_SPT   = 8'd56;
	localparam logic [7:0] IDW_CAP_LO    = 8'd57;
	localparam logic [7:0] IDW_CAP_HI    = 8'd58;
	localparam logic [7:0] IDW_LBA_LO    = 8'd60;
	localparam logic [7:0] IDW_LBA_HI    = 8'd61;
	localparam logic [7:0] IDW_FEAT      = 8'd82;
	localparam int         FEAT_HPA_BIT  = 10;

	// Reset values.
	localparam logic [ST_W-1:0] MASK_RST   = 2'b00;
	localparam logic [31:0]     RDATA_RST  = 32'h0000_0000;

	typedef enum logic [1:0] {HPAL_IDLE, HPAL_EXEC, HPAL_FINISH} hpal_state_t;

endpackage

// >>> hdl/hpal_top.sv
// Host protected area limit keeper with register port and identify data.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hpal_top
	import hpal_pkg::*;
#(
	parameter logic [ADDR_W-1:0] NATIVE_MAX = 28'h0FF_FFFF,
	parameter int                HEADS      = 16,
	parameter int                SPT        = 63
)
(
	input  wire logic        clk_sys_i,    // System clock, 125 MHz
	input  wire logic        rst_n_i,      // Power-on reset, async, active low
	input  wire logic        hw_reset_i,   // Hardware reset pin, active high
	input  wire logic [7:0]  addr_i,       // Register byte address
	input  wire logic [31:0] wdata_i,      // Register write data
	input  wire logic        wr_i,         // Write strobe
	input  wire logic        rd_i,         // Read strobe
	output logic      [31:0] rdata_o,      // Read data, one cycle after strobe
	output logic             irq_o         // Level interrupt
);

	// Hardware reset pin synchroniser.
	logic hw_meta;
	logic hw_sync;
	logic hw_sync_d;
	logic hw_pulse;

	// Register state.
	logic [7:0]        cmd_code;
	logic [ADDR_W-1:0] cmd_addr;
	logic [1:0]        seccnt;
	logic [ST_W-1:0]   status;
	logic [ST_W-1:0]   mask;
	logic [ADDR_W-1:0] result;
	logic [7:0]        id_index;

	// Limit state.
	logic [ADDR_W-1:0] user_max;
	logic [ADDR_W-1:0] nv_max;
	logic              nv_used;
	logic              armed;

	// Command machine.
	hpal_state_t state;
	logic        start;
	logic        cmd_abort;
	logic        cmd_done;
	logic        set_ok;
	logic [ADDR_W-1:0] chs_last;

	// Capacity figures.
	logic [15:0] cap_cyl;
	logic [31:0] cap_chs;
	logic [31:0] cap_lba;

	logic [ST_W-1:0] st_set;
	logic [ST_W-1:0] st_clr;
	logic [15:0]     id_word;

	// Address match used by both the write and read decoders.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Widen an address into a read word.
	function automatic logic [31:0] widen(input logic [ADDR_W-1:0] v);
		widen = {{(32 - ADDR_W){1'b0}}, v};
	endfunction

	hpal_capacity #(
		.HEADS (HEADS),
		.SPT   (SPT)
	) u_capacity (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.max_i     (user_max),
		.cyl_o     (cap_cyl),
		.chs_cap_o (cap_chs),
		.lba_cap_o (cap_lba)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hw_meta   <= 1'b0;
			hw_sync   <= 1'b0;
			hw_sync_d <= 1'b0;
		end
		else
		begin
			hw_meta   <= hw_reset_i;
			hw_sync   <= hw_meta;
			hw_sync_d <= hw_sync;
		end
	end

	assign hw_pulse = hw_sync & ~hw_sync_d;

	// A write to the command register starts a command when idle.
	assign start = wr_i && hit(addr_i, OFS_CMD) && (state == HPAL_IDLE);

	// Parameter registers written by software.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cmd_code <= 8'h00;
			cmd_addr <= '0;
			seccnt   <= 2'b00;
			mask     <= MASK_RST;
			id_index <= 8'h00;
		end
		else if (wr_i)
		begin
			if (hit(addr_i, OFS_CMD) && state == HPAL_IDLE)
				cmd_code <= wdata_i[7:0];
			else if (hit(addr_i, OFS_ADDR))
				cmd_addr <= wdata_i[ADDR_W-1:0];
			else if (hit(addr_i, OFS_SECCNT))
				seccnt <= wdata_i[1:0];
			else if (hit(addr_i, OFS_MASK))
				mask <= wdata_i[ST_W-1:0];
			else if (hit(addr_i, OFS_ID_INDEX))
				id_index <= wdata_i[7:0];
		end
	end

	// Highest block reachable in whole cylinders.
	assign chs_last = cap_chs[ADDR_W-1:0] - {{(ADDR_W - 1){1'b0}}, 1'b1};

	// Command evaluation, done in the execute state from stable registers.
	always_comb
	begin
		cmd_abort = 1'b0;
		set_ok    = 1'b0;
		case (cmd_code)
			CMD_SET_MAX:
			begin
				if (cmd_addr > NATIVE_MAX)
					cmd_abort = 1'b1;
				else if (!armed)
					cmd_abort = 1'b1;
				else if (seccnt[SC_KEEP_BIT] && nv_used)
					cmd_abort = 1'b1;
				else
					set_ok = 1'b1;
			end
			CMD_READ, CMD_WRITE:
			begin
				if (cmd_addr > user_max)
					cmd_abort = 1'b1;
				else if (seccnt[SC_CHS_BIT] && (cap_chs == 32'h0000_0000 || cmd_addr > chs_last))
					cmd_abort = 1'b1;
			end
			default:
				cmd_abort = 1'b0;
		endcase
	end

	assign cmd_done = (state == HPAL_EXEC);

	// The finish state waits one cycle so the capacity figures are settled.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state <= HPAL_IDLE;
		else
		begin
			case (state)
				HPAL_IDLE:
					if (start)
						state <= HPAL_EXEC;
				HPAL_EXEC:
					state <= HPAL_FINISH;
				HPAL_FINISH:
					state <= HPAL_IDLE;
				default:
					state <= HPAL_IDLE;
			endcase
		end
	end

	// Native query arms the next command; any other command disarms it.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			armed <= 1'b0;
		else if (hw_pulse)
			armed <= 1'b0;
		else if (cmd_done)
			armed <= (cmd_code == CMD_READ_NATIVE);
	end

	// Result register holds the address answered by the last native query or accepted set.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			result <= '0;
		else if (cmd_done)
		begin
			if (cmd_code == CMD_READ_NATIVE)
				result <= NATIVE_MAX;
			else if (set_ok)
				result <= cmd_addr;
		end
	end

	// User limit: loaded on an accepted set, restored to the stored limit on hardware reset.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			user_max <= NATIVE_MAX;
		else if (hw_pulse)
			user_max <= nv_max;
		else if (cmd_done && set_ok)
			user_max <= cmd_addr;
	end

	// Stored limit and its once-per-reset guard.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			nv_max  <= NATIVE_MAX;
			nv_used <= 1'b0;
		end
		else if (hw_pulse)
			nv_used <= 1'b0;
		else if (cmd_done && set_ok && seccnt[SC_KEEP_BIT])
		begin
			nv_max  <= cmd_addr;
			nv_used <= 1'b1;
		end
	end

	// Sticky status; a new event wins over the clear of a read.
	always_comb
	begin
		st_set = '0;
		st_clr = '0;
		if (cmd_done)
		begin
			st_set[ST_DONE_BIT]  = 1'b1;
			st_set[ST_ABORT_BIT] = cmd_abort;
		end
		if (rd_i && hit(addr_i, OFS_STATUS))
			st_clr = '1;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			status <= '0;
		else
			status <= (status & ~st_clr) | st_set;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status & mask);
	end

	// Identify data words; the cylinder and capacity words depend on the limit.
	always_comb
	begin
		id_word = 16'h0000;
		case (id_index)
			IDW_CYL, IDW_CUR_CYL:
				id_word = cap_cyl;
			IDW_HEADS, IDW_CUR_HEADS:
				id_word = 16'(HEADS);
			IDW_SPT, IDW_CUR_SPT:
				id_word = 16'(SPT);
			IDW_CAP_LO:
				id_word = cap_chs[15:0];
			IDW_CAP_HI:
				id_word = cap_chs[31:16];
			IDW_LBA_LO:
				id_word = cap_lba[15:0];
			IDW_LBA_HI:
				id_word = cap_lba[31:16];
			IDW_FEAT:
				id_word[FEAT_HPA_BIT] = 1'b1;
			default:
				id_word = 16'h0000;
		endcase
	end

	// Read data stands in the cycle after the strobe; zero otherwise.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_o <= RDATA_RST;
		else if (!rd_i)
			rdata_o <= RDATA_RST;
		else if (hit(addr_i, OFS_CMD))
			rdata_o <= {24'h00_0000, cmd_code};
		else if (hit(addr_i, OFS_ADDR))
			rdata_o <= widen(cmd_addr);
		else if (hit(addr_i, OFS_SECCNT))
			rdata_o <= {30'h0000_0000, seccnt};
		else if (hit(addr_i, OFS_STATUS))
			rdata_o <= {{(32 - ST_W){1'b0}}, status};
		else if (hit(addr_i, OFS_MASK))
			rdata_o <= {{(32 - ST_W){1'b0}}, mask};
		else if (hit(addr_i, OFS_RESULT))
			rdata_o <= widen(result);
		else if (hit(addr_i, OFS_USER_MAX))
			rdata_o <= widen(user_max);
		else if (hit(addr_i, OFS_NATIVE_MAX))
			rdata_o <= widen(NATIVE_MAX);
		else if (hit(addr_i, OFS_ID_INDEX))
			rdata_o <= {24'h00_0000, id_index};
		else if (hit(addr_i, OFS_ID_DATA))
			rdata_o <= {16'h0000, id_word};
		else if (hit(addr_i, OFS_FLAGS))
			rdata_o <= {29'h0000_0000, state != HPAL_IDLE, armed, nv_used};
		else
			rdata_o <= RDATA_RST;
	end

endmodule
`default_nettype wire

// >>> verif/hpal_checker.sv
// Port checks for the host protected area limit block.
`timescale 1ns/1ps
`default_nettype none
module hpal_checker
	import hpal_pkg::*;
#(
	parameter logic [ADDR_W-1:0] NATIVE_MAX = 28'h0FF_FFFF
)
(
	input wire logic        clk_sys_i,  // System clock
	input wire logic        rst_n_i,    // Power-on reset
	input wire logic        hw_reset_i, // Hardware reset pin
	input wire logic [7:0]  addr_i,     // Register address
	input wire logic [31:0] wdata_i,    // Write data
	input wire logic        wr_i,       // Write strobe
	input wire logic        rd_i,       // Read strobe
	input wire logic [31:0] rdata_o,    // Read data
	input wire logic        irq_o       // Interrupt
);
	logic [ST_W-1:0] mask_h;
	logic [7:0]      idx_h;
	logic [1:0]      busy_cnt;
	logic            cmd_ok;
	assign cmd_ok = wr_i && addr_i == OFS_CMD && busy_cnt == 2'd0;
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mask_h   <= MASK_RST;
			idx_h    <= 8'h00;
			busy_cnt <= 2'd0;
		end
		else
		begin
			if (wr_i && addr_i == OFS_MASK)
				mask_h <= wdata_i[ST_W-1:0];
			if (wr_i && addr_i == OFS_ID_INDEX)
				idx_h <= wdata_i[7:0];
			busy_cnt <= cmd_ok ? 2'd2 : (busy_cnt != 2'd0 ? busy_cnt - 2'd1 : 2'd0);
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data not zero outside read answer");
	a_native_query_full: assert property (rd_i && addr_i == OFS_NATIVE_MAX
		|=> rdata_o == 32'(NATIVE_MAX)) else $error("native limit read wrong");
	a_user_max_bound: assert property (rd_i && addr_i == OFS_USER_MAX
		|=> rdata_o <= 32'(NATIVE_MAX)) else $error("user limit above native");
	a_feature_bit_set: assert property (rd_i && addr_i == OFS_ID_DATA && idx_h == IDW_FEAT
		|=> rdata_o[FEAT_HPA_BIT]) else $error("support bit missing");
	a_done_raises_irq: assert property (cmd_ok && mask_h[ST_DONE_BIT] |-> ##3 irq_o)
		else $error("interrupt missing after command");
	a_reset_quiet_out: assert property (disable iff (1'b0) !rst_n_i
		|-> rdata_o == 32'h0000_0000 && !irq_o) else $error("outputs active in reset");
	a_mask_reads_back: assert property (rd_i && addr_i == OFS_MASK
		|=> rdata_o == 32'(mask_h)) else $error("mask read back wrong");
	a_unmapped_read_zero: assert property (rd_i && addr_i > OFS_FLAGS
		|=> rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
bind hpal_top hpal_checker #(.NATIVE_MAX(NATIVE_MAX)) hpal_checker_inst (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .hw_reset_i(hw_reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// >>> verif/hpal_host.sv
// Host model issuing register accesses and commands to the block.
`timescale 1ns/1ps
`default_nettype none
module hpal_host
	import hpal_pkg::*;
(
	input  wire logic        clk_sys_i, // System clock
	output logic      [7:0]  addr_o,    // Register address
	output logic      [31:0] wdata_o,   // Write data
	output logic             wr_o,      // Write strobe
	output logic             rd_o       // Read strobe
);
	initial
	begin
		addr_o  = 8'h00;
		wdata_o = 32'h0000_0000;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
	end
	// Released lines show the inverse of the last value.
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_sys_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic get(input logic [7:0] a);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_sys_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [ADDR_W-1:0] a, input logic keep);
		put(OFS_ADDR, 32'(a));
		put(OFS_SECCNT, {31'h0, keep});
		put(OFS_CMD, {24'h00_0000, c});
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic chs_cmd(input logic [7:0] c, input logic [ADDR_W-1:0] a);
		put(OFS_ADDR, 32'(a));
		put(OFS_SECCNT, 32'h0000_0002);
		put(OFS_CMD, {24'h00_0000, c});
		repeat (3) @(posedge clk_sys_i);
	endtask
	task automatic set_max(input logic [ADDR_W-1:0] a, input logic keep, input logic skip);
		if (!skip)
			cmd(CMD_READ_NATIVE, a, 1'b0);
		cmd(CMD_SET_MAX, a, keep);
	endtask
endmodule
`default_nettype wire

// >>> verif/test_hpal_top.sv
// Self-checking bench for the host protected area limit block.
`timescale 1ns/1ps
`default_nettype none
module test_hpal_top;
	import hpal_pkg::*;
	localparam logic [ADDR_W-1:0] NMAX = 28'h0FF_FFFF;
	localparam int                CYL  = 16 * 63;
	logic               clk_sys_i, rst_n_i, hw_reset_i, wr_i, rd_i, irq_o, rd_seen;
	logic [7:0]         addr_i;
	logic [31:0]        wdata_i, rdata_o;
	logic [ADDR_W-1:0]  a, b;
	int                 fail_count, n_compared;
	logic [31:0]        exp_q[$];
	hpal_host hpal_host_inst (.clk_sys_i(clk_sys_i), .addr_o(addr_i), .wdata_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i));
	hpal_top #(.NATIVE_MAX(NMAX)) hpal_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.hw_reset_i(hw_reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_o(irq_o));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rd_exp(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		hpal_host_inst.get(ad);
	endtask
	task automatic ident(input logic [7:0] w, input logic [31:0] e);
		hpal_host_inst.put(OFS_ID_INDEX, 32'(w));
		rd_exp(OFS_ID_DATA, e);
	endtask
	initial
	begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		if (rd_seen)
			check(rdata_o, exp_q.size() ? exp_q.pop_front() : 32'hxxxx_xxxx);
		rd_seen <= rd_i;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		end_of_test();
	end
	initial
	begin
		rst_n_i = 1'b0;
		hw_reset_i = 1'b0;
		rd_seen = 1'b0;
		void'($urandom(32'hc463a979));
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		hpal_host_inst.put(OFS_MASK, 32'h0000_0003);
		rd_exp(OFS_MASK, 32'h0000_0003);
		rd_exp(OFS_NATIVE_MAX, 32'(NMAX));
		ident(IDW_FEAT, 32'h0000_0400);
		$display("test identity done");
		a = 28'($urandom_range(32'h00F_FFFE, 32'h0000_1000));
		hpal_host_inst.set_max(a, 1'b0, 1'b0);
		@(negedge clk_sys_i);
		check(32'(irq_o), 32'h0000_0001);
		rd_exp(OFS_STATUS, 32'h0000_0001);
		repeat (2) @(negedge clk_sys_i);
		check(32'(irq_o), 32'h0000_0000);
		rd_exp(OFS_USER_MAX, 32'(a));
		rd_exp(OFS_NATIVE_MAX, 32'(NMAX));
		ident(IDW_LBA_LO, (32'(a) + 1) & 32'h0000_FFFF);
		ident(IDW_LBA_HI, (32'(a) + 1) >> 16);
		ident(IDW_CYL, (32'(a) + 1) / CYL);
		ident(IDW_CUR_CYL, (32'(a) + 1) / CYL);
		ident(IDW_CAP_LO, ((32'(a) + 1) / CYL * CYL) & 32'h0000_FFFF);
		$display("test volatile set done");
		hpal_host_inst.cmd(CMD_READ, a, 1'b0);
		rd_exp(OFS_STATUS, 32'h0000_0001);
		hpal_host_inst.cmd(CMD_WRITE, a + 28'd1, 1'b0);
		rd_exp(OFS_STATUS, 32'h0000_0003);
		b = 28'((32'(a) + 1) / CYL * CYL - 1);
		hpal_host_inst.chs_cmd(CMD_READ, b);
		rd_exp(OFS_STATUS, 32'h0000_0001);
		hpal_host_inst.chs_cmd(CMD_WRITE, b + 28'd1);
		rd_exp(OFS_STATUS, 32'h0000_0003);
		$display("test access bound done");
		hpal_host_inst.set_max(a - 28'd1, 1'b0, 1'b1);
		rd_exp(OFS_STATUS, 32'h0000_0003);
		hpal_host_inst.set_max(NMAX + 28'd1, 1'b0, 1'b0);
		rd_exp(OFS_STATUS, 32'h0000_0003);
		rd_exp(OFS_USER_MAX, 32'(a));
		$display("test refusals done");
		b = a - 28'd5;
		hpal_host_inst.set_max(b, 1'b1, 1'b0);
		hpal_host_inst.set_max(b - 28'd1, 1'b1, 1'b0);
		rd_exp(OFS_STATUS, 32'h0000_0003);
		hpal_host_inst.set_max(NMAX, 1'b0, 1'b0);
		rd_exp(OFS_USER_MAX, 32'(NMAX));
		hw_reset_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		hw_reset_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rd_exp(OFS_USER_MAX, 32'(b));
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd_exp(OFS_USER_MAX, 32'(NMAX));
		$display("test reset restore done");
		rd_exp(8'h2C, 32'h0000_0000);
		hpal_host_inst.cmd(CMD_READ_NATIVE, a, 1'b0);
		@(negedge clk_sys_i);
		check(32'(irq_o), 32'h0000_0000);
		repeat (3) @(posedge clk_sys_i);
		check(32'(exp_q.size()), 32'h0000_0000);
		$display("test unmapped and mask done");
		end_of_test();
	end
endmodule
`default_nettype wire
